// ==== design/ppic_consts.svh ====
`ifndef PPIC_CONSTS_SVH
`define PPIC_CONSTS_SVH

// register indices; the byte address is four times the index
`define PPIC_IDX_POSTED0     10'h0DA
`define PPIC_IDX_POSTED1     10'h0DB
`define PPIC_IDX_POSTED2     10'h0DC
`define PPIC_IDX_MASK3       10'h0DE
`define PPIC_IDX_MASK2       10'h0DF
`define PPIC_IDX_MASK0       10'h0E0
`define PPIC_IDX_MASK1       10'h0E1
`define PPIC_IDX_VCLR        10'h0E2

// implemented source bits of the three groups, packed group2..group0
`define PPIC_VALID_SRC       24'h16_7F_FF
`define PPIC_RST_BYTE        8'h00

// soft_post_enable position inside mask register 3
`define PPIC_SOFT_POST_BIT   7

// edge-posted port sources in the flat source vector
`define PPIC_GPIO0_BIT       4
`define PPIC_GPIO1_BIT       7
`define PPIC_GPIO2_BIT       20
`define PPIC_GPIO_MASK       24'h10_00_90

// dispatch sequence, counted in cycles from the first dispatch cycle
`define PPIC_DISPATCH_CYCLES 4'd13
`define PPIC_STEP_PUSH_PCH   4'd0
`define PPIC_STEP_PUSH_PCL   4'd1
`define PPIC_STEP_PUSH_FLAGS 4'd2
`define PPIC_STEP_FLAG_CLR   4'd3

// return sequence steps
`define PPIC_STEP_POP_FLAGS  4'd0
`define PPIC_STEP_POP_PCL    4'd1
`define PPIC_STEP_POP_PCH    4'd2
`define PPIC_STEP_RESTORE    4'd3

`endif

// ==== design/ppic_pkg.sv ====
package ppic_pkg;

   // sequencer states
   typedef enum logic [1:0] {
      PPIC_IDLE,
      PPIC_DISPATCH,
      PPIC_RETURN
   } ppic_state_e;

   // from the cpu core
   typedef struct packed {
      logic        instr_boundary;
      logic        handler_return;
      logic [15:0] pc;
      logic [7:0]  flags;
      logic [7:0]  pop_data;
   } ppic_cpu_in_s;

   // to the cpu core
   typedef struct packed {
      logic        irq_active;
      logic        take_ack;
      logic        push_valid;
      logic [7:0]  push_data;
      logic        flags_clear;
      logic        pc_load;
      logic [15:0] pc_value;
      logic        pop_req;
      logic        restore_valid;
      logic [15:0] restore_pc;
      logic [7:0]  restore_flags;
   } ppic_cpu_out_s;

   // whole state of the controller
   typedef struct packed {
      logic [23:0]   posted;
      logic [23:0]   mask;
      logic          soft_post_enable;
      ppic_state_e   state;
      logic [3:0]    cnt;
      logic [7:0]    vector;
      logic [15:0]   saved_pc;
      logic [7:0]    saved_flags;
      logic [31:0]   prdata;
      logic          pslverr;
      ppic_cpu_out_s out;
   } ppic_regs_s;

endpackage : ppic_pkg

// ==== design/ppic_edge_det.sv ====
`timescale 1ns/1ps
`default_nettype none

module ppic_edge_det
   import ppic_pkg::*;
#(
   parameter int W = 3
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] level,
   output logic      [W-1:0] rise
);

   typedef struct packed {
      logic [W-1:0] prev;
   } ppic_edge_s;

   ppic_edge_s r;
   ppic_edge_s next_r;

   // remember last level
   always_comb
   begin
      next_r      = r;
      next_r.prev = level;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         r <= '0;
      else if (ce)
         r <= next_r;
   end

   // low-to-high transition only, a held level posts once
   assign rise = level & ~r.prev;

endmodule : ppic_edge_det

`default_nettype wire

// ==== design/ppic_prio_enc.sv ====
`timescale 1ns/1ps
`default_nettype none

module ppic_prio_enc
   import ppic_pkg::*;
(
   input  wire logic [23:0] pending,
   output logic             hit,
   output logic [4:0]       src,
   output logic [7:0]       vector
);

   localparam int NSRC = 18;

   // flat source index and priority number, highest priority first
   localparam logic [4:0] SRC_IDX [NSRC] = '{
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h05, 5'h08, 5'h09,
      5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h11, 5'h12, 5'h14, 5'h06};
   localparam logic [4:0] SRC_PRI [NSRC] = '{
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
      5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h11, 5'h12, 5'h14, 5'h19};

   // scan lowest priority first so the highest one is left standing
   always_comb
   begin
      hit    = 1'b0;
      src    = 5'h00;
      vector = 8'h00;
      for (int i = NSRC - 1; i >= 0; i--)
      begin
         if (pending[SRC_IDX[i]])
         begin
            hit    = 1'b1;
            src    = SRC_IDX[i];
            vector = {1'b0, SRC_PRI[i], 2'b00};
         end
      end
   end

endmodule : ppic_prio_enc

`default_nettype wire

// ==== design/ppic_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ppic_consts.svh"

// Operation
// - a source event sets that source's posted flag
// - posted flag holds until taken or cleared by software
// - posted flag counts as pending only while its mask bit is one
// - encoder picks highest pending; taken only with global enable set
// - clearing a mask bit keeps posted flags and posting alive
// - active on event, mask unmasking, or enable rising with pending
// - port sources post on a rising edge, not on a level
// - dispatch starts only once the current instruction has finished
// - dispatch lasts exactly 13 cycles as an automatic call
// - push pc high byte, pc low byte, then flags, in order
// - after pushing, clear whole flag register, disabling interrupts
// - pc high byte zeroed, pc low byte loaded with the vector
// - return restores pc and flags, saved enable re-enables
// - pending requests at return are served before next instruction
// - nesting allowed when a handler sets the enable bit again
// - reading posted registers shows one for each posted source
// - writing zero to a posted bit clears that flag
// - writing one with soft post enabled posts that source
// - group 0 bit map: ports, sleep, inputs, serial, power fault
// - group 1 bit map: timers, bus, endpoints; bit 7 reserved
// - group 2 bit map: port 2, input 2, counter wrap only
// - with soft post disabled, written ones do nothing
// - with soft post enabled, written zeros are ignored
// - vector register reads top vector; any write clears all pending
// - fixed priority per source, vector equals priority times four

module ppic_top
   import ppic_pkg::*;
#(
   parameter int FLAG_IE_BIT = 0
)
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          pclken,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [23:0]   src_event,
   input  wire logic [2:0]    gpio_level,
   input  wire ppic_cpu_in_s  cpu_in,
   output ppic_cpu_out_s      cpu_out
);

   ppic_regs_s  r;
   ppic_regs_s  next_r;

   logic [9:0]  reg_idx;
   logic [1:0]  sel_grp;
   logic        is_posted;
   logic        is_mask;
   logic        is_mask3;
   logic        is_vclr;
   logic        mapped;
   logic        wr_fire;
   logic        rd_setup;
   logic [7:0]  wb;
   logic [23:0] lane;
   logic [23:0] wb24;
   logic [2:0]  gpio_rise;
   logic [23:0] gpio_flat;
   logic [23:0] hw_set;
   logic [23:0] soft_set;
   logic [23:0] soft_clr;
   logic [23:0] vclr_clr;
   logic [23:0] take_clr;
   logic [23:0] pending;
   logic        global_irq_enable;
   logic        req;
   logic        enc_hit;
   logic [4:0]  enc_src;
   logic [7:0]  enc_vec;
   logic        take;
   logic [15:0] take_pc;
   logic [7:0]  take_flags;
   logic [7:0]  rd_byte;

   // port sources go through edge detection
   ppic_edge_det #(
      .W     (3)
   ) u_gpio_edge (
      .clk   (pclk),
      .rst_n (presetn),
      .ce    (pclken),
      .level (gpio_level),
      .rise  (gpio_rise)
   );

   // highest pending source and its vector
   ppic_prio_enc u_prio (
      .pending (pending),
      .hit     (enc_hit),
      .src     (enc_src),
      .vector  (enc_vec)
   );

   // register decode, index is the word address
   assign reg_idx = paddr[11:2];

   always_comb
   begin
      sel_grp   = 2'd0;
      is_posted = 1'b0;
      is_mask   = 1'b0;
      is_mask3  = 1'b0;
      is_vclr   = 1'b0;
      case (reg_idx)
         `PPIC_IDX_POSTED0:
         begin
            is_posted = 1'b1;
            sel_grp   = 2'd0;
         end
         `PPIC_IDX_POSTED1:
         begin
            is_posted = 1'b1;
            sel_grp   = 2'd1;
         end
         `PPIC_IDX_POSTED2:
         begin
            is_posted = 1'b1;
            sel_grp   = 2'd2;
         end
         `PPIC_IDX_MASK0:
         begin
            is_mask = 1'b1;
            sel_grp = 2'd0;
         end
         `PPIC_IDX_MASK1:
         begin
            is_mask = 1'b1;
            sel_grp = 2'd1;
         end
         `PPIC_IDX_MASK2:
         begin
            is_mask = 1'b1;
            sel_grp = 2'd2;
         end
         `PPIC_IDX_MASK3:
            is_mask3 = 1'b1;
         `PPIC_IDX_VCLR:
            is_vclr = 1'b1;
         default:
            sel_grp = 2'd0;
      endcase
   end

   assign mapped = (is_posted | is_mask | is_mask3 | is_vclr)
                   & (paddr[1:0] == 2'b00);

   // apb handshake, zero wait states while enabled
   assign pready   = pclken;
   assign wr_fire  = psel & penable & pwrite & pstrb[0] & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign prdata   = r.prdata;
   assign pslverr  = r.pslverr;

   // write byte spread over the selected group lane
   assign wb   = pwdata[7:0];
   assign lane = 24'h00_00_FF << {sel_grp, 3'b000};
   assign wb24 = {wb, wb, wb};

   // flat vector of port edges
   always_comb
   begin
      gpio_flat                  = 24'h00_00_00;
      gpio_flat[`PPIC_GPIO0_BIT] = gpio_rise[0];
      gpio_flat[`PPIC_GPIO1_BIT] = gpio_rise[1];
      gpio_flat[`PPIC_GPIO2_BIT] = gpio_rise[2];
   end

   // hardware posting, independent of the masks
   assign hw_set = (src_event & ~`PPIC_GPIO_MASK) | gpio_flat;

   // software posting and clearing through the posted registers
   assign soft_set = (is_posted & wr_fire & r.soft_post_enable)
                     ? (lane & wb24) : 24'h00_00_00;
   assign soft_clr = (is_posted & wr_fire & ~r.soft_post_enable)
                     ? (lane & ~wb24) : 24'h00_00_00;
   assign vclr_clr = (is_vclr & wr_fire)
                     ? pending : 24'h00_00_00;

   // mask gates posted flags into pending ones
   assign pending = r.posted & r.mask;

   // request level: follows events, unmasking and enable rising
   assign global_irq_enable = cpu_in.flags[FLAG_IE_BIT];
   assign req = enc_hit & global_irq_enable;

   // taking at instruction end, or right after a return restores
   always_comb
   begin
      take       = 1'b0;
      take_pc    = cpu_in.pc;
      take_flags = cpu_in.flags;
      case (r.state)
         PPIC_IDLE:
            take = cpu_in.instr_boundary & ~cpu_in.handler_return
                   & req;
         PPIC_RETURN:
         begin
            take_pc    = r.out.restore_pc;
            take_flags = r.out.restore_flags;
            take = (r.cnt == `PPIC_STEP_RESTORE) & enc_hit
                   & r.out.restore_flags[FLAG_IE_BIT];
         end
         default:
            take = 1'b0;
      endcase
   end

   // taken source loses its posted flag
   assign take_clr = take ? (24'h00_00_01 << enc_src)
                          : 24'h00_00_00;

   // read byte of the addressed register
   always_comb
   begin
      rd_byte = `PPIC_RST_BYTE;
      if (is_posted)
         rd_byte = r.posted[{sel_grp, 3'b000} +: 8];
      else if (is_mask)
         rd_byte = r.mask[{sel_grp, 3'b000} +: 8];
      else if (is_mask3)
         rd_byte = {r.soft_post_enable, 7'h00};
      else if (is_vclr)
         rd_byte = enc_vec;
   end

   // next state
   always_comb
   begin
      next_r = r;

      // set wins over every clear in the same cycle
      next_r.posted = ((r.posted & ~(soft_clr | vclr_clr | take_clr))
                       | hw_set | soft_set)
                      & `PPIC_VALID_SRC;

      // mask registers
      if (is_mask & wr_fire)
         next_r.mask = ((r.mask & ~lane) | (lane & wb24))
                       & `PPIC_VALID_SRC;
      if (is_mask3 & wr_fire)
         next_r.soft_post_enable = wb[`PPIC_SOFT_POST_BIT];

      // read data and error captured in the setup cycle
      if (rd_setup)
         next_r.prdata = {24'h00_00_00, rd_byte};
      if (psel & ~penable)
         next_r.pslverr = ~mapped;

      // sequencer
      case (r.state)
         PPIC_IDLE:
         begin
            if (cpu_in.handler_return)
            begin
               next_r.state = PPIC_RETURN;
               next_r.cnt   = 4'd0;
            end
         end
         PPIC_DISPATCH:
         begin
            if (r.cnt == `PPIC_DISPATCH_CYCLES - 4'd1)
               next_r.state = PPIC_IDLE;
            else
               next_r.cnt = r.cnt + 4'd1;
         end
         PPIC_RETURN:
         begin
            // stack pops in reverse push order
            case (r.cnt)
               `PPIC_STEP_POP_FLAGS:
                  next_r.out.restore_flags = cpu_in.pop_data;
               `PPIC_STEP_POP_PCL:
                  next_r.out.restore_pc[7:0] = cpu_in.pop_data;
               `PPIC_STEP_POP_PCH:
                  next_r.out.restore_pc[15:8] = cpu_in.pop_data;
               default:
                  next_r.out.restore_pc = r.out.restore_pc;
            endcase
            if (r.cnt == `PPIC_STEP_RESTORE)
               next_r.state = PPIC_IDLE;
            else
               next_r.cnt = r.cnt + 4'd1;
         end
         default:
            next_r.state = PPIC_IDLE;
      endcase

      // acceptance starts the automatic call
      if (take)
      begin
         next_r.state       = PPIC_DISPATCH;
         next_r.cnt         = 4'd0;
         next_r.vector      = enc_vec;
         next_r.saved_pc    = take_pc;
         next_r.saved_flags = take_flags;
      end

      // outputs to the core, registered; push, flag clear, pc load and pop from the coming state, restore_valid from the current one
      next_r.out.irq_active = req;
      next_r.out.take_ack   = take;
      next_r.out.push_valid = (next_r.state == PPIC_DISPATCH)
                              & (next_r.cnt <= `PPIC_STEP_PUSH_FLAGS);
      case (next_r.cnt)
         `PPIC_STEP_PUSH_PCH:
            next_r.out.push_data = next_r.saved_pc[15:8];
         `PPIC_STEP_PUSH_PCL:
            next_r.out.push_data = next_r.saved_pc[7:0];
         `PPIC_STEP_PUSH_FLAGS:
            next_r.out.push_data = next_r.saved_flags;
         default:
            next_r.out.push_data = 8'h00;
      endcase
      next_r.out.flags_clear = (next_r.state == PPIC_DISPATCH)
                               & (next_r.cnt == `PPIC_STEP_FLAG_CLR);
      next_r.out.pc_load = (next_r.state == PPIC_DISPATCH)
                           & (next_r.cnt == `PPIC_DISPATCH_CYCLES - 4'd1);
      next_r.out.pc_value = {8'h00, next_r.vector};
      next_r.out.pop_req = (next_r.state == PPIC_RETURN)
                           & (next_r.cnt <= `PPIC_STEP_POP_PCH);
      next_r.out.restore_valid = (r.state == PPIC_RETURN)
                                 & (r.cnt == `PPIC_STEP_RESTORE);
   end

   // single state register, frozen while the clock enable is low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         r <= '0;
      else if (pclken)
         r <= next_r;
   end

   assign cpu_out = r.out;

endmodule : ppic_top

`default_nettype wire

// ==== tb/ppic_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ppic_consts.svh"

module ppic_asserts
   import ppic_pkg::*;
#(
   parameter int FLAG_IE_BIT = 0
)
(
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          pclken,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [11:0]   paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [3:0]    pstrb,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic [23:0]   src_event,
   input wire logic [2:0]    gpio_level,
   input wire ppic_cpu_in_s  cpu_in,
   input wire ppic_cpu_out_s cpu_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // dispatch sequence timing and contents
   property p_len;
      cpu_out.take_ack |-> ##12 cpu_out.pc_load;
   endproperty
   a_len: assert property (p_len) else $error("late pc load");
   property p_gap;
      cpu_out.take_ack |=> !cpu_out.take_ack [*8];
   endproperty
   a_gap: assert property (p_gap) else $error("take overlap");
   property p_push;
      cpu_out.take_ack && !cpu_out.restore_valid |->
         cpu_out.push_valid && cpu_out.push_data == $past(cpu_in.pc[15:8])
         ##1 cpu_out.push_valid && cpu_out.push_data == $past(cpu_in.pc[7:0], 2)
         ##1 cpu_out.push_valid && cpu_out.push_data == $past(cpu_in.flags, 3);
   endproperty
   a_push: assert property (p_push) else $error("bad push");
   // take straight out of a return pushes the restored context
   property p_push_ret;
      cpu_out.take_ack && cpu_out.restore_valid |->
         cpu_out.push_data == cpu_out.restore_pc[15:8]
         ##1 cpu_out.push_data == cpu_out.restore_pc[7:0]
         ##1 cpu_out.push_data == cpu_out.restore_flags;
   endproperty
   a_push_ret: assert property (p_push_ret) else $error("bad chained push");
   property p_act;
      cpu_out.take_ack && !cpu_out.restore_valid |-> cpu_out.irq_active;
   endproperty
   a_act: assert property (p_act) else $error("take while inactive");
   property p_clr;
      cpu_out.take_ack |-> ##3 cpu_out.flags_clear && !cpu_out.push_valid;
   endproperty
   a_clr: assert property (p_clr) else $error("no flag clear");
   property p_vec;
      cpu_out.pc_load |-> cpu_out.pc_value[15:8] == 8'h00
         && cpu_out.pc_value[1:0] == 2'b00 && cpu_out.pc_value[7:0] != 8'h00;
   endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_gie;
      cpu_out.take_ack && !cpu_out.restore_valid |->
         $past(cpu_in.flags[FLAG_IE_BIT]) && $past(cpu_in.instr_boundary);
   endproperty
   a_gie: assert property (p_gie) else $error("bad take");
   // return pops flags, pc low, pc high
   property p_ret;
      cpu_out.restore_valid |-> $past(cpu_out.pop_req, 2)
         && !$past(cpu_out.pop_req)
         && cpu_out.restore_pc == {$past(cpu_in.pop_data, 2),
                                   $past(cpu_in.pop_data, 3)}
         && cpu_out.restore_flags == $past(cpu_in.pop_data, 4);
   endproperty
   a_ret: assert property (p_ret) else $error("bad restore");
   // reserved bits of groups 1 and 2 read zero
   property p_rsv1;
      psel && !penable && !pwrite && pclken
         && paddr == {`PPIC_IDX_POSTED1, 2'b00}
         |=> (prdata & 32'hFFFF_FF80) == 32'h0;
   endproperty
   a_rsv1: assert property (p_rsv1) else $error("group1 reserved");
   property p_rsv2;
      psel && !penable && !pwrite && pclken
         && paddr == {`PPIC_IDX_POSTED2, 2'b00}
         |=> (prdata & 32'hFFFF_FFE9) == 32'h0;
   endproperty
   a_rsv2: assert property (p_rsv2) else $error("group2 reserved");
endmodule : ppic_asserts

bind ppic_top ppic_asserts #(.FLAG_IE_BIT(FLAG_IE_BIT)) u_asserts (
   .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .src_event(src_event), .gpio_level(gpio_level), .cpu_in(cpu_in),
   .cpu_out(cpu_out));
`default_nettype wire

// ==== tb/ppic_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ppic_cpu_model
   import ppic_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire ppic_cpu_out_s cpu_out,
   input  wire logic          ret,
   input  wire logic          set_ie,
   output ppic_cpu_in_s       cpu_in
);
   logic [7:0]  stk [0:15];
   logic [3:0]  sp;
   logic [1:0]  ph;
   logic        ib;
   logic        hr;
   logic [15:0] pc;
   logic [7:0]  fl;
   logic [7:0]  top;

   // stack byte only while popping, inverted otherwise
   assign top = stk[sp - 4'd1];
   assign cpu_in = '{ib, hr, pc, fl, cpu_out.pop_req ? top : ~top};

   // core: boundary every fourth cycle, stack, flag register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ph <= 2'h0;
         sp <= 4'h0;
         ib <= 1'b0;
         hr <= 1'b0;
         pc <= 16'h1230;
         fl <= 8'h00;
      end
      else
      begin
         ph <= ph + 2'd1;
         ib <= (ph == 2'd3);
         hr <= ret;
         if (ib)
            pc <= pc + 16'd1;
         if (cpu_out.push_valid)
         begin
            stk[sp] <= cpu_out.push_data;
            sp <= sp + 4'd1;
         end
         if (cpu_out.pop_req)
            sp <= sp - 4'd1;
         if (set_ie)
            fl[0] <= 1'b1;
         if (cpu_out.flags_clear)
            fl <= 8'h00;
         if (cpu_out.pc_load)
            pc <= cpu_out.pc_value;
         if (cpu_out.restore_valid)
         begin
            pc <= cpu_out.restore_pc;
            fl <= cpu_out.restore_flags;
         end
      end
   end
endmodule : ppic_cpu_model
`default_nettype wire

// ==== tb/tb_ppic_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ppic_consts.svh"

module tb_ppic_top
   import ppic_pkg::*;
   ;
   localparam logic [9:0] P0 = `PPIC_IDX_POSTED0;
   localparam logic [9:0] P1 = `PPIC_IDX_POSTED1;
   localparam logic [9:0] P2 = `PPIC_IDX_POSTED2;
   localparam logic [9:0] M0 = `PPIC_IDX_MASK0;
   localparam logic [9:0] M3 = `PPIC_IDX_MASK3;
   localparam logic [9:0] VC = `PPIC_IDX_VCLR;
   logic          pclk = 1'b0;
   logic          presetn = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [11:0]   paddr = 12'h000;
   logic [31:0]   pwdata = 32'h0;
   logic [23:0]   src_event = 24'h0;
   logic [2:0]    gpio_level = 3'h0;
   logic          ret = 1'b0;
   logic          set_ie = 1'b0;
   logic [31:0]   prdata;
   logic [31:0]   rdat;
   logic          pready;
   logic          pslverr;
   logic          rerr;
   logic [15:0]   lastv;
   ppic_cpu_in_s  cpu_in;
   ppic_cpu_out_s cpu_out;
   int            fails = 0;
   int            comparisons = 0;
   int            loads = 0;

   always #4 pclk = ~pclk;

   ppic_top u_dut (
      .pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_event(src_event), .gpio_level(gpio_level), .cpu_in(cpu_in),
      .cpu_out(cpu_out));

   ppic_cpu_model u_cpu (
      .pclk(pclk), .presetn(presetn), .cpu_out(cpu_out), .ret(ret),
      .set_ie(set_ie), .cpu_in(cpu_in));

   // count vector loads on the cpu side
   always @(posedge pclk)
   begin
      if (cpu_out.pc_load === 1'b1)
      begin
         loads <= loads + 1;
         lastv <= cpu_out.pc_value;
      end
   end

   task automatic finish_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      apb(1'b1, {i, 2'b00}, d);
   endtask : wr

   task automatic rd(input logic [9:0] i, input logic [7:0] e);
      apb(1'b0, {i, 2'b00}, 8'h00);
      chk({24'h0, e}, rdat);
   endtask : rd

   task automatic ev(input logic [23:0] m);
      @(posedge pclk);
      src_event <= m;
      @(posedge pclk);
      src_event <= 24'h0;
   endtask : ev

   task automatic kick(input logic r);
      @(posedge pclk);
      ret <= r;
      set_ie <= !r;
      @(posedge pclk);
      ret <= 1'b0;
      set_ie <= 1'b0;
   endtask : kick

   task automatic waitld(input int n);
      int k;
      k = 0;
      while (loads < n && k < 100)
      begin
         @(posedge pclk);
         k++;
      end
      chk(32'(n), 32'(loads));
   endtask : waitld

   task automatic t_reset;
      logic [9:0] ix [8];
      ix = '{P0, P1, P2, M0, `PPIC_IDX_MASK1, `PPIC_IDX_MASK2, M3, VC};
      foreach (ix[i])
         rd(ix[i], 8'h00);
      apb(1'b0, 12'h369, 8'h00);
      chk(32'h1, {31'h0, rerr});
      chk(32'h0, rdat);
      $display("reset test done");
   endtask : t_reset

   task automatic t_post;
      ev(24'hFF_FF_FF);
      rd(P0, 8'h6F);
      rd(P1, 8'h7F);
      rd(P2, 8'h06);
      wr(M0, 8'h00);
      wr(P0, 8'hFE);
      rd(P0, 8'h6E);
      wr(P1, 8'hFF);
      rd(P1, 8'h7F);
      wr(P0, 8'h00);
      wr(P1, 8'h00);
      wr(P2, 8'h00);
      rd(P1, 8'h00);
      $display("post test done");
   endtask : t_post

   task automatic t_gpio;
      @(posedge pclk);
      gpio_level <= 3'b111;
      repeat (4) @(posedge pclk);
      rd(P0, 8'h90);
      rd(P2, 8'h10);
      wr(P0, 8'h00);
      wr(P2, 8'h00);
      rd(P0, 8'h00);
      gpio_level <= 3'b000;
      $display("edge test done");
   endtask : t_gpio

   task automatic t_soft;
      wr(M3, 8'hFF);
      rd(M3, 8'h80);
      wr(P1, 8'h05);
      rd(P1, 8'h05);
      wr(P1, 8'h00);
      rd(P1, 8'h05);
      wr(M3, 8'h00);
      wr(P1, 8'h00);
      rd(P1, 8'h00);
      $display("soft post test done");
   endtask : t_soft

   task automatic t_vec;
      ev(24'h22);
      rd(VC, 8'h00);
      wr(M0, 8'h20);
      rd(VC, 8'h1C);
      wr(M0, 8'h22);
      rd(VC, 8'h08);
      wr(M0, 8'h20);
      wr(VC, 8'h5A);
      rd(P0, 8'h02);
      wr(M0, 8'h00);
      wr(P0, 8'h00);
      $display("vector test done");
   endtask : t_vec

   task automatic t_cpu;
      wr(M0, 8'h03);
      ev(24'h01);
      kick(1'b0);
      waitld(1);
      chk(32'h4, {16'h0, lastv});
      chk(32'h0, {24'h0, cpu_in.flags});
      rd(P0, 8'h00);
      ev(24'h02);
      repeat (30) @(posedge pclk);
      waitld(1);
      chk(32'h0, {31'h0, cpu_out.irq_active});
      kick(1'b0);
      waitld(2);
      chk(32'h8, {16'h0, lastv});
      ev(24'h01);
      kick(1'b1);
      waitld(3);
      chk(32'h4, {16'h0, lastv});
      // two returns unwind both remaining stack frames
      repeat (2)
      begin
         repeat (8) @(posedge pclk);
         kick(1'b1);
      end
      repeat (10) @(posedge pclk);
      chk(32'h1, {31'h0, cpu_in.flags[0]});
      waitld(3);
      $display("dispatch test done");
   endtask : t_cpu

   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_post;
      t_gpio;
      t_soft;
      t_vec;
      t_cpu;
      finish_test;
   end

   // watchdog against a hung handshake
   initial
   begin
      #100000;
      fails++;
      finish_test;
   end
endmodule : tb_ppic_top
`default_nettype wire
